// >>> design/sfp_top.sv
// servo fault/protection register bank and fault logic
// assumes pin inputs are asynchronous; others on i_clk
`timescale 1ns/10ps
module sfp_top import sfp_pkg::*; #(
   parameter int unsigned P_MS_CYC = MS_CYC
) (
   input wire logic i_clk, // 50 MHz clock
   input wire logic i_rst_n, // async reset, low
   input wire logic i_ce, // clock enable
   input wire logic [15:0] i_addr, // register address
   input wire logic [31:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [31:0] o_rdata, // read data
   output logic o_irq, // interrupt level
   input wire logic i_stopped, // drive at standstill
   input wire logic i_cfg_load, // power-on settings load
   input wire logic i_sto, // safe torque off pin
   input wire logic i_sto_noise, // sto noise seen
   input wire logic i_ovl_alarm, // overload alarm
   input wire logic i_ovl_fault, // overload fault
   input wire logic i_stall_hot, // stall overheat
   input wire logic i_mt_ovf, // multi-turn overflow
   input wire logic [31:0] i_abs_pos, // abs position
   input wire logic i_enc_sample, // one exchange done
   input wire logic i_enc_err, // exchange failed
   input wire logic i_ovs_pt, // masked overspeed pt
   input wire logic i_index_pulse, // index pulse pin
   input wire logic i_quad_a, // quadrature a pin
   input wire logic i_quad_b, // quadrature b pin
   input wire logic i_fc_a, // closed-loop a pin
   input wire logic i_fc_b, // closed-loop b pin
   input wire logic i_fc_z, // closed-loop z pin
   input wire logic i_fc_break, // wire-break pin
   output logic [NFLT-1:0] o_filt, // filtered pins
   output sfp_fault_type o_fault, // fault levels
   output logic o_fault_do, // fault digital output
   output logic [15:0] o_lpf_ms, // low-pass time
   output logic [15:0] o_avg_ms, // average window
   output logic [4:0] o_comp // compensation select
);
   // register file
   logic [15:0] sto_q, idx_q, ovl_q, quad_q, fcl_q;
   logic [15:0] stime_q, sten_q, mth_q, tol_q, lin_q;
   logic [31:0] fwd_q, rev_q;
   logic [NEV-1:0] stat_q, ien_q;
   // power-on effective copies
   logic [4:0] idx_a_q;
   logic [7:0] quad_a_q;
   logic [15:0] fcl_a_q;
   logic [4:0] tol_a_q;
   logic [31:0] rdata_d;
   logic wr_ok;
   always_comb begin
      wr_ok = i_stopped;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sto_q <= R_STO;
         idx_q <= R_IDX;
         o_lpf_ms <= R_LPF;
         ovl_q <= R_OVL;
         o_avg_ms <= R_AVG;
         quad_q <= R_QUAD;
         fcl_q <= R_FCL;
         stime_q <= R_STIME;
         sten_q <= R_STEN;
         mth_q <= R_MTH;
         o_comp <= R_COMP[4:0];
         fwd_q <= R_FWD;
         rev_q <= R_REV;
         tol_q <= R_TOL;
         lin_q <= 16'h0000;
         ien_q <= '0;
      end else if (i_ce && i_wr) begin
         case (i_addr)
            A_STO: sto_q <= i_wdata[15:0];
            A_IDX: if (wr_ok) idx_q <= i_wdata[15:0];
            A_LPF: if (wr_ok) o_lpf_ms <= i_wdata[15:0];
            A_OVL: ovl_q <= i_wdata[15:0];
            A_AVG: if (wr_ok) o_avg_ms <= i_wdata[15:0];
            A_QUAD: if (wr_ok) quad_q <= i_wdata[15:0];
            A_FCL: if (wr_ok) fcl_q <= i_wdata[15:0];
            A_STIME: stime_q <= i_wdata[15:0];
            A_STEN: sten_q <= i_wdata[15:0];
            A_MTH: mth_q <= i_wdata[15:0];
            A_COMP: if (wr_ok) o_comp <= i_wdata[4:0];
            A_FWD: if (wr_ok) fwd_q <= i_wdata;
            A_REV: if (wr_ok) rev_q <= i_wdata;
            A_TOL: tol_q <= i_wdata[15:0];
            A_IEN: ien_q <= i_wdata[NEV-1:0];
            A_LIN: lin_q <= i_wdata[15:0];
            default: ;
         endcase
      end
   end
   // settings that only act after a power-on load
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         idx_a_q <= R_IDX[4:0];
         quad_a_q <= R_QUAD[7:0];
         fcl_a_q <= R_FCL;
         tol_a_q <= R_TOL[4:0];
      end else if (i_ce && i_cfg_load) begin
         idx_a_q <= idx_q[4:0];
         quad_a_q <= quad_q[7:0];
         fcl_a_q <= fcl_q;
         tol_a_q <= tol_q[4:0];
      end
   end
   always_comb begin
      rdata_d = 32'h00000000;
      case (i_addr)
         A_STO: rdata_d = {16'h0000, sto_q};
         A_IDX: rdata_d = {16'h0000, idx_q};
         A_LPF: rdata_d = {16'h0000, o_lpf_ms};
         A_OVL: rdata_d = {16'h0000, ovl_q};
         A_AVG: rdata_d = {16'h0000, o_avg_ms};
         A_QUAD: rdata_d = {16'h0000, quad_q};
         A_FCL: rdata_d = {16'h0000, fcl_q};
         A_STIME: rdata_d = {16'h0000, stime_q};
         A_STEN: rdata_d = {16'h0000, sten_q};
         A_MTH: rdata_d = {16'h0000, mth_q};
         A_COMP: rdata_d = {27'h0000000, o_comp};
         A_FWD: rdata_d = fwd_q;
         A_REV: rdata_d = rev_q;
         A_TOL: rdata_d = {16'h0000, tol_q};
         A_STAT: rdata_d = {{(32-NEV){1'b0}}, stat_q};
         A_IEN: rdata_d = {{(32-NEV){1'b0}}, ien_q};
         A_LIN: rdata_d = {16'h0000, lin_q};
         default: rdata_d = 32'h00000000;
      endcase
   end
   // data valid only the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h00000000;
      end else if (i_ce) begin
         o_rdata <= i_rd ? rdata_d : 32'h00000000;
      end
   end
   // pin synchronisers
   localparam int unsigned NSYN = NFLT + 1;
   logic [NSYN-1:0] syn1_q, syn2_q, pins;
   always_comb begin
      pins = {i_sto, i_fc_break, i_fc_z, i_fc_b, i_fc_a,
              i_quad_b, i_quad_a, i_index_pulse};
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         syn1_q <= '0;
         syn2_q <= '0;
      end else if (i_ce) begin
         syn1_q <= pins;
         syn2_q <= syn1_q;
      end
   end
   logic sto_s;
   always_comb begin
      sto_s = syn2_q[NSYN-1];
   end
   // filter lengths: index, quad a/b, closed-loop a/b/z, break
   logic [10:0] flen [NFLT];
   always_comb begin
      flen[0] = sfp_cyc({3'h0, idx_a_q});
      flen[1] = sfp_cyc(quad_a_q);
      flen[2] = sfp_cyc(quad_a_q);
      flen[3] = sfp_cyc(fcl_a_q[B_FC_PULSE +: 8]);
      flen[4] = sfp_cyc(fcl_a_q[B_FC_PULSE +: 8]);
      flen[5] = sfp_cyc(fcl_a_q[B_FC_PULSE +: 8]);
      flen[6] = sfp_cyc(fcl_a_q[B_FC_BREAK +: 8]);
   end
   genvar gi;
   generate
      for (gi = 0; gi < NFLT; gi++) begin : g_flt
         sfp_filter u_flt (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_ce(i_ce),
            .i_in(syn2_q[gi]),
            .i_len(flen[gi]),
            .o_out(o_filt[gi])
         );
      end
   endgenerate
   // millisecond tick and stall overheat timer
   logic [15:0] tick_q;
   logic [15:0] stall_ms_q;
   logic ms_tick;
   always_comb begin
      ms_tick = (tick_q == 16'(P_MS_CYC - 1));
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_q <= 16'h0000;
      end else if (i_ce) begin
         tick_q <= ms_tick ? 16'h0000 : tick_q + 16'h0001;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stall_ms_q <= 16'h0000;
      end else if (i_ce) begin
         if (!i_stall_hot || sten_q[0] == 1'b0) begin
            stall_ms_q <= 16'h0000;
         end else if (ms_tick && stall_ms_q != 16'hFFFF) begin
            stall_ms_q <= stall_ms_q + 16'h0001;
         end
      end
   end
   // consecutive encoder error and overspeed counters
   logic [5:0] err_cnt_q, ovs_cnt_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         err_cnt_q <= 6'h00;
         ovs_cnt_q <= 6'h00;
      end else if (i_ce && i_enc_sample) begin
         if (!i_enc_err) begin
            err_cnt_q <= 6'h00;
         end else if (err_cnt_q != 6'h3F) begin
            err_cnt_q <= err_cnt_q + 6'h01;
         end
         if (!i_ovs_pt) begin
            ovs_cnt_q <= 6'h00;
         end else if (ovs_cnt_q != 6'h3F) begin
            ovs_cnt_q <= ovs_cnt_q + 6'h01;
         end
      end
   end
   // fault levels
   sfp_fault_type flt_d;
   always_comb begin
      flt_d.sto_fault = sto_s && sto_q[B_STO_FLT];
      flt_d.sto_status = sto_s && !sto_q[B_STO_FLT];
      flt_d.noise_diag = i_sto_noise && !sto_q[B_STO_NOISE];
      flt_d.ovl_alarm = i_ovl_alarm && !ovl_q[0];
      flt_d.ovl_fault = i_ovl_fault && !ovl_q[0];
      flt_d.stall = sten_q[0] && i_stall_hot
                    && stall_ms_q >= stime_q;
      flt_d.mt_overflow = i_mt_ovf
                          && !(lin_q[0] && mth_q[0]);
      flt_d.fwd_limit = $signed(i_abs_pos) > $signed(fwd_q);
      flt_d.rev_limit = $signed(i_abs_pos) < $signed(rev_q);
      flt_d.enc_fail = err_cnt_q > {1'b0, tol_a_q}
                       || ovs_cnt_q > {1'b0, tol_a_q};
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fault <= '0;
         o_fault_do <= 1'b0;
      end else if (i_ce) begin
         o_fault <= flt_d;
         o_fault_do <= flt_d.sto_fault;
      end
   end
   // sticky status: a new event beats a clear in the same cycle
   logic [NEV-1:0] clr;
   always_comb begin
      clr = (i_wr && i_addr == A_CLR) ? i_wdata[NEV-1:0] : '0;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_q <= '0;
      end else if (i_ce) begin
         stat_q <= (stat_q & ~clr) | o_fault;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= |(((stat_q & ~clr) | o_fault) & ien_q);
      end
   end
   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sto_show_a: assert property (
      i_ce && sto_s && !sto_q[0] |=> !o_fault_do && o_fault.sto_status)
      else $error("sto status raised a fault");
   sto_fault_a: assert property (
      i_ce && sto_s && sto_q[0] |=> o_fault_do && !o_fault.sto_status)
      else $error("sto fault not raised");
   noise_hide_a: assert property (
      i_ce && sto_q[2] |=> !o_fault.noise_diag)
      else $error("hidden noise diagnosis shown");
   ovl_hide_a: assert property (
      i_ce && ovl_q[0] |=> !o_fault.ovl_alarm && !o_fault.ovl_fault)
      else $error("hidden overload reported");
   stall_time_a: assert property (
      i_ce && stall_ms_q < stime_q |=> !o_fault.stall)
      else $error("stall fault before its time");
   stall_off_a: assert property (
      i_ce && !sten_q[0] |=> !o_fault.stall)
      else $error("stall fault while disabled");
   fwd_limit_a: assert property (
      i_ce && $signed(i_abs_pos) > $signed(fwd_q) |=> o_fault.fwd_limit)
      else $error("forward limit missed");
   rev_limit_a: assert property (
      i_ce && $signed(i_abs_pos) < $signed(rev_q) |=> o_fault.rev_limit)
      else $error("reverse limit missed");
   enc_fail_a: assert property (
      i_ce && err_cnt_q <= {1'b0, tol_a_q} && ovs_cnt_q <= {1'b0, tol_a_q}
      |=> !o_fault.enc_fail)
      else $error("comm failure within tolerance");
endmodule

// >>> design/sfp_pkg.sv
// servo fault/protection config: constants, layouts, helpers
// assumes a 50 MHz drive clock and one register port
package sfp_pkg;
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned STEP_NS = 25;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYC = MS_NS / CLK_NS;
   localparam logic [15:0] A_STO = 16'h0A15;
   localparam logic [15:0] A_IDX = 16'h0A17;
   localparam logic [15:0] A_LPF = 16'h0A19;
   localparam logic [15:0] A_OVL = 16'h0A1A;
   localparam logic [15:0] A_AVG = 16'h0A1B;
   localparam logic [15:0] A_QUAD = 16'h0A1C;
   localparam logic [15:0] A_FCL = 16'h0A1D;
   localparam logic [15:0] A_STIME = 16'h0A20;
   localparam logic [15:0] A_STEN = 16'h0A21;
   localparam logic [15:0] A_MTH = 16'h0A24;
   localparam logic [15:0] A_COMP = 16'h0A28;
   localparam logic [15:0] A_FWD = 16'h0A29;
   localparam logic [15:0] A_REV = 16'h0A2B;
   localparam logic [15:0] A_TOL = 16'h0A32;
   localparam logic [15:0] A_STAT = 16'h0A80;
   localparam logic [15:0] A_CLR = 16'h0A81;
   localparam logic [15:0] A_IEN = 16'h0A82;
   localparam logic [15:0] A_LIN = 16'h0A90;
   localparam logic [15:0] R_STO = 16'h0000;
   localparam logic [15:0] R_IDX = 16'h000F;
   localparam logic [15:0] R_LPF = 16'h0000;
   localparam logic [15:0] R_OVL = 16'h0000;
   localparam logic [15:0] R_AVG = 16'h0032;
   localparam logic [15:0] R_QUAD = 16'h0002;
   localparam logic [15:0] R_FCL = 16'h100F;
   localparam logic [15:0] R_STIME = 16'h00C8;
   localparam logic [15:0] R_STEN = 16'h0001;
   localparam logic [15:0] R_MTH = 16'h0000;
   localparam logic [15:0] R_COMP = 16'h0006;
   localparam logic [31:0] R_FWD = 32'h7FFFFFFF;
   localparam logic [31:0] R_REV = 32'h80000000;
   localparam logic [15:0] R_TOL = 16'h001F;
   localparam logic [15:0] M_COMP = 16'h001F;
   localparam int unsigned B_STO_FLT = 0;
   localparam int unsigned B_STO_NOISE = 2;
   localparam int unsigned B_FC_PULSE = 0;
   localparam int unsigned B_FC_BREAK = 8;
   localparam int unsigned NFLT = 7;
   typedef struct packed {
      logic enc_fail;
      logic rev_limit;
      logic fwd_limit;
      logic mt_overflow;
      logic stall;
      logic ovl_fault;
      logic ovl_alarm;
      logic noise_diag;
      logic sto_status;
      logic sto_fault;
   } sfp_fault_type;
   localparam int unsigned NEV = $bits(sfp_fault_type);
   // 25 ns steps to 20 ns cycles, rounded up
   function automatic logic [10:0] sfp_cyc(input logic [7:0] s);
      logic [10:0] p;
      p = {3'h0, s} * 11'h005 + 11'h003;
      return p >> 2;
   endfunction
endpackage

// >>> design/sfp_filter.sv
// input level filter for one synchronised signal
// assumes the input is already on i_clk
`timescale 1ns/10ps
module sfp_filter import sfp_pkg::*; (
   input wire logic i_clk, // drive clock
   input wire logic i_rst_n, // async reset, low
   input wire logic i_ce, // clock enable
   input wire logic i_in, // synchronised input
   input wire logic [10:0] i_len, // stable cycles
   output logic o_out // filtered level
);
   logic [10:0] cnt_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 11'h000;
         o_out <= 1'b0;
      end else if (i_ce) begin
         if (i_in == o_out) begin
            cnt_q <= 11'h000;
         end else if (cnt_q + 11'h001 >= i_len) begin
            o_out <= i_in;
            cnt_q <= 11'h000;
         end else begin
            cnt_q <= cnt_q + 11'h001;
         end
      end
   end
endmodule

// >>> test/sfp_enc_model.sv
// encoder exchanges, quadrature and index pulse seen by the protection bank
// assumes the bench calls its tasks from one process, just after a clock edge
`timescale 1ns/10ps
module sfp_enc_model (
   input wire logic i_clk, // drive clock
   output logic o_sample, // exchange done
   output logic o_err, // exchange failed
   output logic o_ovs, // masked overspeed point
   output logic o_index, // index pulse pin
   output logic o_qa, // quadrature a
   output logic o_qb // quadrature b
);
   logic [1:0] ph_q;
   initial begin
      ph_q = 2'h0;
      o_sample = 1'h0;
      o_err = 1'h0;
      o_ovs = 1'h0;
      o_index = 1'h0;
   end
   assign o_qa = ph_q[1];
   assign o_qb = ph_q[1] ^ ph_q[0];
   // qualifiers flip between exchanges so a stale level never looks valid
   task automatic exch(input int n, input logic e, input logic o);
      for (int k = 0; k < n; k++) begin
         @(posedge i_clk);
         o_sample <= 1'h1;
         o_err <= e;
         o_ovs <= o;
         ph_q <= ph_q + 2'h1;
         @(posedge i_clk);
         o_sample <= 1'h0;
         o_err <= ~e;
         o_ovs <= ~o;
         repeat (2) @(posedge i_clk);
      end
   endtask
   task automatic index(input int w);
      @(posedge i_clk);
      o_index <= 1'h1;
      repeat (w) @(posedge i_clk);
      o_index <= 1'h0;
   endtask
endmodule

// >>> test/sfp_top_test.sv
// self-checking bench for the fault/protection register bank
// assumes the encoder model stands on the far side; 20 ns clock
`timescale 1ns/10ps
module sfp_top_test import sfp_pkg::*;;
   logic i_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic i_wr = 1'h0, i_rd = 1'h0, i_stopped = 1'h1, i_cfg_load = 1'h0, i_sto = 1'h0;
   logic i_sto_noise = 1'h0, i_ovl_alarm = 1'h0, i_ovl_fault = 1'h0;
   logic i_stall_hot = 1'h0, i_mt_ovf = 1'h0;
   logic i_ce = 1'h1, i_fc_break = 1'h0;
   logic [15:0] i_addr = 16'h0000;
   logic [31:0] i_wdata = 32'h0, i_abs_pos = 32'h0, o_rdata, rd_v;
   logic o_irq, o_fault_do, enc_s, enc_e, enc_o, idx, qa, qb;
   logic [NFLT-1:0] o_filt;
   sfp_fault_type o_fault;
   logic [15:0] o_lpf_ms, o_avg_ms;
   logic [4:0] o_comp;
   int bad_count = 0, compares = 0, n;
   logic [15:0] ra [14] = '{A_STO, A_IDX, A_LPF, A_OVL, A_AVG, A_QUAD, A_FCL, A_STIME,
      A_STEN, A_MTH, A_COMP, A_FWD, A_REV, A_TOL};
   logic [31:0] rv [14] = '{R_STO, R_IDX, R_LPF, R_OVL, R_AVG, R_QUAD, R_FCL, R_STIME,
      R_STEN, R_MTH, R_COMP, R_FWD, R_REV, R_TOL};
   // written values set up the later scenarios: stall off, tolerance 3, limits +-100
   logic [31:0] wv [14] = '{32'h5, 32'h1F, 32'h1388, 32'h1, 32'h64, 32'hFF, 32'hFFFF,
      32'hA, 32'h0, 32'h1, 32'h1F, 32'h64, 32'hFFFFFF9C, 32'h3};

   always #10 i_clk = ~i_clk;

   sfp_enc_model enc_u (.i_clk(i_clk), .o_sample(enc_s), .o_err(enc_e), .o_ovs(enc_o),
      .o_index(idx), .o_qa(qa), .o_qb(qb));

   sfp_top #(.P_MS_CYC(10)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_irq(o_irq), .i_stopped(i_stopped), .i_cfg_load(i_cfg_load), .i_sto(i_sto),
      .i_sto_noise(i_sto_noise), .i_ovl_alarm(i_ovl_alarm), .i_ovl_fault(i_ovl_fault),
      .i_stall_hot(i_stall_hot), .i_mt_ovf(i_mt_ovf), .i_abs_pos(i_abs_pos),
      .i_enc_sample(enc_s), .i_enc_err(enc_e), .i_ovs_pt(enc_o), .i_index_pulse(idx),
      .i_quad_a(qa), .i_quad_b(qb), .i_fc_a(qa), .i_fc_b(qb), .i_fc_z(idx),
      .i_fc_break(i_fc_break), .o_filt(o_filt), .o_fault(o_fault), .o_fault_do(o_fault_do),
      .o_lpf_ms(o_lpf_ms), .o_avg_ms(o_avg_ms), .o_comp(o_comp));

   task automatic stop_test();
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic tmo(input int lim);
      if (n >= lim) begin
         chk(32'h0, 32'h1, "wait ran out");
         stop_test();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string m);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1;
      rd_v = o_rdata;
      chk(rd_v, e, m);
   endtask
   task automatic pulse_load();
      @(posedge i_clk);
      i_cfg_load <= 1'h1;
      @(posedge i_clk);
      i_cfg_load <= 1'h0;
   endtask
   task automatic rst();
      @(posedge i_clk);
      i_rst_n <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'h1;
   endtask
   task automatic defaults();
      for (int k = 0; k < 14; k++) rdc(ra[k], rv[k], "reset value");
      chk(o_comp, 32'h6, "comp reset");
      chk(o_avg_ms, 32'h32, "avg reset");
      chk(o_lpf_ms, 32'h0, "lpf reset");
   endtask
   task automatic pos(input logic [31:0] p, input logic f, input logic r);
      @(posedge i_clk);
      i_abs_pos <= p;
      settle(3);
      chk(o_fault.fwd_limit, f, "fwd limit");
      chk(o_fault.rev_limit, r, "rev limit");
   endtask

   initial begin
      rst();
      defaults();
      @(posedge i_clk);
      i_stopped <= 1'h0;
      wr(A_IDX, 32'h0);
      wr(A_FWD, 32'h0);
      rdc(A_IDX, 32'hF, "idx written at run");
      rdc(A_FWD, 32'h7FFFFFFF, "fwd written at run");
      @(posedge i_clk);
      i_stopped <= 1'h1;
      wr(16'h0A16, 32'h1234);
      rdc(16'h0A16, 32'h0, "unmapped");
      rdc(A_CLR, 32'h0, "clear reads");
      // a write while the enable is low must not land
      i_ce <= 1'h0;
      wr(A_STO, 32'h1);
      i_ce <= 1'h1;
      rdc(A_STO, 32'h0, "frozen write");
      for (int k = 0; k < 14; k++) wr(ra[k], wv[k]);
      for (int k = 0; k < 14; k++) rdc(ra[k], wv[k], "readback");
      chk(o_comp, 32'h1F, "comp");
      chk(o_lpf_ms, 32'h1388, "lpf");
      chk(o_avg_ms, 32'h64, "avg");
      @(posedge i_clk);
      i_sto <= 1'h1;
      i_sto_noise <= 1'h1;
      settle(5);
      chk(o_fault.sto_fault, 32'h1, "sto fault");
      chk(o_fault_do, 32'h1, "fault out");
      chk(o_fault.noise_diag, 32'h0, "noise hidden");
      wr(A_STO, 32'h2);
      settle(2);
      chk(o_fault.sto_fault, 32'h0, "sto no fault");
      chk(o_fault_do, 32'h0, "fault out idle");
      chk(o_fault.sto_status, 32'h1, "sto status");
      chk(o_fault.noise_diag, 32'h1, "noise shown");
      i_sto <= 1'h0;
      i_sto_noise <= 1'h0;
      enc_u.exch(4, 1'h1, 1'h0);
      settle(2);
      chk(o_fault.enc_fail, 32'h0, "tolerance before load");
      // default lengths: quad 3, closed-loop 19, break 20 cycles
      i_fc_break <= 1'h1;
      enc_u.exch(2, 1'h0, 1'h0);
      settle(25);
      chk(o_filt, 32'h5E, "pin filters");
      i_ovl_alarm <= 1'h1;
      i_ovl_fault <= 1'h1;
      wr(A_CLR, 32'h3FF);
      wr(A_IEN, 32'h18);
      settle(2);
      chk(o_fault.ovl_alarm | o_fault.ovl_fault | o_irq, 32'h0, "overload hidden");
      wr(A_OVL, 32'h0);
      settle(3);
      chk({o_fault.ovl_alarm, o_fault.ovl_fault, o_irq}, 32'h7, "overload shown");
      i_ovl_alarm <= 1'h0;
      i_ovl_fault <= 1'h0;
      wr(A_IEN, 32'h0);
      settle(2);
      chk(o_irq, 32'h0, "irq masked");
      rdc(A_STAT, 32'h18, "status sticky");
      wr(A_IEN, 32'h18);
      settle(2);
      chk(o_irq, 32'h1, "irq enabled");
      wr(A_CLR, 32'h18);
      settle(2);
      chk(o_irq, 32'h0, "irq cleared");
      rdc(A_STAT, 32'h0, "status cleared");
      i_mt_ovf <= 1'h1;
      settle(3);
      chk(o_fault.mt_overflow, 32'h1, "mt outside linear");
      wr(A_LIN, 32'h1);
      settle(2);
      chk(o_fault.mt_overflow, 32'h0, "mt hidden");
      wr(A_MTH, 32'h0);
      settle(2);
      chk(o_fault.mt_overflow, 32'h1, "mt shown");
      i_mt_ovf <= 1'h0;
      i_stall_hot <= 1'h1;
      settle(150);
      chk(o_fault.stall, 32'h0, "stall disabled");
      i_stall_hot <= 1'h0;
      wr(A_STEN, 32'h1);
      @(posedge i_clk);
      i_stall_hot <= 1'h1;
      for (n = 0; n < 300 && o_fault.stall !== 1'h1; n++) settle(1);
      tmo(300);
      chk(n >= 90 && n <= 105, 32'h1, "stall time");
      i_stall_hot <= 1'h0;
      pos(32'h64, 1'h0, 1'h0);
      pos(32'h65, 1'h1, 1'h0);
      pos(32'hFFFFFF9C, 1'h0, 1'h0);
      pos(32'hFFFFFF9B, 1'h0, 1'h1);
      pos(32'h0, 1'h0, 1'h0);
      enc_u.index(12);
      for (n = 0; n < 30 && o_filt[0] !== 1'h1; n++) settle(1);
      chk(n, 32'd30, "short index blocked");
      fork
         enc_u.index(40);
      join_none
      for (n = 0; n < 60 && o_filt[0] !== 1'h1; n++) settle(1);
      tmo(60);
      chk(n >= 19 && n <= 24, 32'h1, "index delay");
      settle(60);
      wr(A_IDX, 32'h0);
      pulse_load();
      fork
         enc_u.index(2);
      join_none
      for (n = 0; n < 10 && o_filt[0] !== 1'h1; n++) settle(1);
      tmo(10);
      enc_u.exch(1, 1'h0, 1'h0);
      enc_u.exch(3, 1'h1, 1'h0);
      settle(2);
      chk(o_fault.enc_fail, 32'h0, "at tolerance");
      enc_u.exch(1, 1'h1, 1'h0);
      settle(2);
      chk(o_fault.enc_fail, 32'h1, "beyond tolerance");
      rst();
      defaults();
      wr(A_TOL, 32'h3);
      pulse_load();
      enc_u.exch(4, 1'h0, 1'h1);
      settle(2);
      chk(o_fault.enc_fail, 32'h1, "overspeed points");
      stop_test();
   end
endmodule
